// File: inc/mfib_regs.svh
`ifndef MFIB_REGS_SVH
`define MFIB_REGS_SVH

`define MFIB_OFF_MISC 8'h00
`define MFIB_OFF_TIMER 8'h04
`define MFIB_OFF_UART 8'h08
`define MFIB_OFF_STAT 8'h0C
`define MFIB_OFF_MASK 8'h10

`define MFIB_BIT_SERIAL 7
`define MFIB_BIT_EEPROM 5
`define MFIB_BIT_LOWV 4
`define MFIB_BIT_CMP_A 5
`define MFIB_BIT_CMP_P 4
`define MFIB_BIT_UART_B 5
`define MFIB_BIT_UART_A 4

`define MFIB_IMPL_MISC 8'hFF
`define MFIB_IMPL_TIMER 8'hFF
`define MFIB_IMPL_UART 8'h33
`define MFIB_FLAG_MISC 8'hB0
`define MFIB_FLAG_TIMER 8'h30
`define MFIB_FLAG_UART 8'h30

`define MFIB_RST_VAL 8'h00
`define MFIB_STAT_RST 3'h0
`define MFIB_RESP_OKAY 2'h0
`define MFIB_RESP_SLVERR 2'h2

`endif

// File: inc/mfib_pkg.sv
package mfib_pkg;

   typedef struct packed {
      logic serial;
      logic eeprom;
      logic low_voltage;
      logic cmp_a;
      logic cmp_p;
      logic uart_a;
      logic uart_b;
   } mfib_events_t;

   typedef struct packed {
      logic uart;
      logic timer3;
      logic misc;
   } mfib_req_t;

endpackage : mfib_pkg

// File: hw/mfib_flag_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "mfib_regs.svh"

module mfib_flag_reg import mfib_pkg::*; #(
   parameter logic [7:0] IMPL_MASK = 8'hFF,
   parameter logic [7:0] FLAG_MASK = 8'h30
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] set_ev,
   output logic [7:0] q,
   output logic req
);

   logic [7:0] q_ff;
   logic [7:0] nxt_q;

   always_comb begin
      nxt_q = q_ff;
      if (wr_en) begin
         nxt_q = wr_data & IMPL_MASK;
      end
      nxt_q = nxt_q | (set_ev & FLAG_MASK);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q_ff <= `MFIB_RST_VAL;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign q = q_ff;
   assign req = |(q_ff[7:4] & q_ff[3:0] & FLAG_MASK[7:4]);

   a_set_beats_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_en && |(set_ev & FLAG_MASK)) |=> ((q_ff & $past(set_ev & FLAG_MASK))
      == $past(set_ev & FLAG_MASK)))
      else $error("event lost against a same-cycle clear");

   a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      (q_ff & ~IMPL_MASK) == 8'h00)
      else $error("unimplemented bit holds a one");

endmodule : mfib_flag_reg
`default_nettype wire

// File: hw/mfib_top.sv
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "mfib_regs.svh"

module mfib_top import mfib_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire mfib_events_t events,
   output mfib_req_t req,
   output logic irq,
   output logic wake
);

   // write channel state
   logic aw_got_ff;
   logic nxt_aw_got;
   logic [7:0] awaddr_ff;
   logic [7:0] nxt_awaddr;
   logic w_got_ff;
   logic nxt_w_got;
   logic [7:0] wdata_ff;
   logic [7:0] nxt_wdata;
   logic wstrb0_ff;
   logic nxt_wstrb0;
   logic bvalid_ff;
   logic nxt_bvalid;
   logic [1:0] bresp_ff;
   logic [1:0] nxt_bresp;
   logic wr_fire;
   logic wr_hit;

   // read channel state
   logic rvalid_ff;
   logic nxt_rvalid;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic [1:0] rresp_ff;
   logic [1:0] nxt_rresp;

   // flag registers
   logic we_misc;
   logic we_timer;
   logic we_uart;
   logic [7:0] ev_misc;
   logic [7:0] ev_timer;
   logic [7:0] ev_uart;
   logic [7:0] misc_q;
   logic [7:0] timer_q;
   logic [7:0] uart_q;
   logic req_misc;
   logic req_timer;
   logic req_uart;

   // outputs, status and mask
   mfib_req_t req_ff;
   mfib_req_t nxt_req;
   logic [2:0] stat_ff;
   logic [2:0] nxt_stat;
   logic [2:0] mask_ff;
   logic [2:0] nxt_mask;
   logic [2:0] stat_set;
   logic irq_ff;
   logic nxt_irq;
   logic wake_ff;
   logic nxt_wake;

   assign s_axi_awready = !aw_got_ff && !bvalid_ff;
   assign s_axi_wready = !w_got_ff && !bvalid_ff;
   assign s_axi_arready = !rvalid_ff;
   assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;

   // byte lane 0 carries all register data
   assign we_misc = wr_fire && wstrb0_ff && (awaddr_ff == `MFIB_OFF_MISC);
   assign we_timer = wr_fire && wstrb0_ff && (awaddr_ff == `MFIB_OFF_TIMER);
   assign we_uart = wr_fire && wstrb0_ff && (awaddr_ff == `MFIB_OFF_UART);

   always_comb begin
      wr_hit = 1'b0;
      if (awaddr_ff == `MFIB_OFF_MISC) begin
         wr_hit = 1'b1;
      end else if (awaddr_ff == `MFIB_OFF_TIMER) begin
         wr_hit = 1'b1;
      end else if (awaddr_ff == `MFIB_OFF_UART) begin
         wr_hit = 1'b1;
      end else if (awaddr_ff == `MFIB_OFF_STAT) begin
         wr_hit = 1'b1;
      end else if (awaddr_ff == `MFIB_OFF_MASK) begin
         wr_hit = 1'b1;
      end
   end

   always_comb begin
      nxt_aw_got = aw_got_ff;
      nxt_awaddr = awaddr_ff;
      nxt_w_got = w_got_ff;
      nxt_wdata = wdata_ff;
      nxt_wstrb0 = wstrb0_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      // address and data may come in either order
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_aw_got = 1'b1;
         nxt_awaddr = {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_w_got = 1'b1;
         nxt_wdata = s_axi_wdata[7:0];
         nxt_wstrb0 = s_axi_wstrb[0];
      end
      if (wr_fire) begin
         nxt_aw_got = 1'b0;
         nxt_w_got = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = wr_hit ? `MFIB_RESP_OKAY : `MFIB_RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         w_got_ff <= 1'b0;
         wdata_ff <= 8'h00;
         wstrb0_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `MFIB_RESP_OKAY;
      end else begin
         aw_got_ff <= nxt_aw_got;
         awaddr_ff <= nxt_awaddr;
         w_got_ff <= nxt_w_got;
         wdata_ff <= nxt_wdata;
         wstrb0_ff <= nxt_wstrb0;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
      end
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;

   always_comb begin
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = `MFIB_RESP_OKAY;
         nxt_rdata = 32'h0000_0000;
         if ({s_axi_araddr[7:2], 2'h0} == `MFIB_OFF_MISC) begin
            nxt_rdata[7:0] = misc_q;
         end else if ({s_axi_araddr[7:2], 2'h0} == `MFIB_OFF_TIMER) begin
            nxt_rdata[7:0] = timer_q;
         end else if ({s_axi_araddr[7:2], 2'h0} == `MFIB_OFF_UART) begin
            nxt_rdata[7:0] = uart_q;
         end else if ({s_axi_araddr[7:2], 2'h0} == `MFIB_OFF_STAT) begin
            nxt_rdata[2:0] = stat_ff;
         end else if ({s_axi_araddr[7:2], 2'h0} == `MFIB_OFF_MASK) begin
            nxt_rdata[2:0] = mask_ff;
         end else begin
            nxt_rresp = `MFIB_RESP_SLVERR;
         end
      end else if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= `MFIB_RESP_OKAY;
      end else begin
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // event pulses placed on their flag positions
   always_comb begin
      ev_misc = 8'h00;
      ev_timer = 8'h00;
      ev_uart = 8'h00;
      ev_misc[`MFIB_BIT_SERIAL] = events.serial;
      ev_misc[`MFIB_BIT_EEPROM] = events.eeprom;
      ev_misc[`MFIB_BIT_LOWV] = events.low_voltage;
      ev_timer[`MFIB_BIT_CMP_A] = events.cmp_a;
      ev_timer[`MFIB_BIT_CMP_P] = events.cmp_p;
      ev_uart[`MFIB_BIT_UART_B] = events.uart_b;
      ev_uart[`MFIB_BIT_UART_A] = events.uart_a;
   end

   mfib_flag_reg #(
      .IMPL_MASK(`MFIB_IMPL_MISC),
      .FLAG_MASK(`MFIB_FLAG_MISC)
   ) u_misc (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(we_misc),
      .wr_data(wdata_ff),
      .set_ev(ev_misc),
      .q(misc_q),
      .req(req_misc)
   );

   mfib_flag_reg #(
      .IMPL_MASK(`MFIB_IMPL_TIMER),
      .FLAG_MASK(`MFIB_FLAG_TIMER)
   ) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(we_timer),
      .wr_data(wdata_ff),
      .set_ev(ev_timer),
      .q(timer_q),
      .req(req_timer)
   );

   mfib_flag_reg #(
      .IMPL_MASK(`MFIB_IMPL_UART),
      .FLAG_MASK(`MFIB_FLAG_UART)
   ) u_uart (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(we_uart),
      .wr_data(wdata_ff),
      .set_ev(ev_uart),
      .q(uart_q),
      .req(req_uart)
   );

   assign stat_set = {|ev_uart, |ev_timer, |ev_misc};

   always_comb begin
      nxt_mask = mask_ff;
      nxt_stat = stat_ff;
      if (wr_fire && wstrb0_ff && (awaddr_ff == `MFIB_OFF_MASK)) begin
         nxt_mask = wdata_ff[2:0];
      end
      if (wr_fire && wstrb0_ff && (awaddr_ff == `MFIB_OFF_STAT)) begin
         nxt_stat = stat_ff & ~wdata_ff[2:0];
      end
      nxt_stat = nxt_stat | stat_set;
      nxt_req.misc = req_misc;
      nxt_req.timer3 = req_timer;
      nxt_req.uart = req_uart;
      nxt_irq = |(nxt_stat & nxt_mask);
      nxt_wake = |{ev_misc, ev_timer, ev_uart};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_ff <= `MFIB_STAT_RST;
         stat_ff <= `MFIB_STAT_RST;
         req_ff <= '0;
         irq_ff <= 1'b0;
         wake_ff <= 1'b0;
      end else begin
         mask_ff <= nxt_mask;
         stat_ff <= nxt_stat;
         req_ff <= nxt_req;
         irq_ff <= nxt_irq;
         wake_ff <= nxt_wake;
      end
   end

   assign req = req_ff;
   assign irq = irq_ff;
   assign wake = wake_ff;

   a_serial_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      events.serial |=> misc_q[`MFIB_BIT_SERIAL])
      else $error("serial event did not set its flag");

   a_misc_enable_write: assert property (@(posedge aclk) disable iff (!aresetn)
      (we_misc && (ev_misc == 8'h00)) |=> (misc_q == $past(wdata_ff)))
      else $error("misc register write not stored");

   a_cmp_flags_set: assert property (@(posedge aclk) disable iff (!aresetn)
      (events.cmp_a || events.cmp_p) |=> (timer_q[5] || !$past(events.cmp_a))
      && (timer_q[4] || !$past(events.cmp_p)))
      else $error("compare events did not set their flags");

   a_timer_req_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      (timer_q[5] && timer_q[1]) |=> req.timer3)
      else $error("enabled compare-a flag gave no request");

   a_uart_b_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      events.uart_b |=> uart_q[`MFIB_BIT_UART_B])
      else $error("uart-b event did not set its flag");

   a_uart_en_write: assert property (@(posedge aclk) disable iff (!aresetn)
      (we_uart && !events.uart_a && !events.uart_b)
      |=> (uart_q == ($past(wdata_ff) & `MFIB_IMPL_UART)))
      else $error("uart register write wrong");

   a_uart_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready
      && ({s_axi_araddr[7:2], 2'h0} == `MFIB_OFF_UART)) |-> (s_axi_rdata[7:0] & 8'hCC) == 8'h00)
      else $error("uart reserved bits read nonzero");

   a_reset_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> (misc_q == 8'h00) && (timer_q == 8'h00) && (uart_q == 8'h00))
      else $error("registers not clear after reset");

   a_no_req_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
      req.misc |-> $past((misc_q[7] && misc_q[3]) || (misc_q[5] && misc_q[1])
      || (misc_q[4] && misc_q[0])))
      else $error("misc request without an enabled flag");

   a_wake_on_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      events.low_voltage |=> wake ##1 (!wake || ($past(events) != 7'h00)))
      else $error("flag event did not wake");

   a_uart_combined: assert property (@(posedge aclk) disable iff (!aresetn)
      req.uart |-> $past((uart_q[5] && uart_q[1]) || (uart_q[4] && uart_q[0])))
      else $error("uart request without an enabled flag");

endmodule : mfib_top
`default_nettype wire

// File: testbench/multifunction_irq_flag_bank_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "mfib_regs.svh"

module multifunction_irq_flag_bank_test import mfib_pkg::*;;
   logic aclk;
   logic aresetn;
   logic [7:0] s_axi_awaddr;
   logic s_axi_awvalid;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_wvalid;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready;
   logic [7:0] s_axi_araddr;
   logic s_axi_arvalid;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready;
   mfib_events_t events;
   mfib_req_t req;
   logic irq;
   logic wake;
   int n_mismatch;
   int comparisons;
   logic [7:0] offs [5] = '{`MFIB_OFF_MISC, `MFIB_OFF_TIMER, `MFIB_OFF_UART, `MFIB_OFF_STAT,
      `MFIB_OFF_MASK};
   logic [7:0] impl [3] = '{8'hFF, 8'hFF, 8'h33};
   // event order: serial, eeprom, low-v, cmp_a, cmp_p, uart_a, uart_b
   logic [7:0] flag_of [7] = '{8'h80, 8'h20, 8'h10, 8'h20, 8'h10, 8'h10, 8'h20};
   int reg_of [7] = '{0, 0, 0, 1, 1, 2, 2};

   mfib_top i_mfib_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .events(events), .req(req),
      .irq(irq), .wake(wake));

   initial begin
      aclk = 1'h0;
      forever #25 aclk = ~aclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // bready is raised only once both halves are taken, so back-to-back calls never
   // assign it twice in one step
   task automatic axi_wr(input logic [7:0] addr, input logic [7:0] data, output logic [1:0] resp);
      logic aw_ok;
      logic w_ok;
      logic aw_hit;
      logic w_hit;
      int t;
      aw_ok = 1'h0;
      w_ok = 1'h0;
      t = 0;
      // start on a rising edge even when called after a falling one
      @(posedge aclk);
      s_axi_awaddr <= addr;
      s_axi_wdata <= {24'h000000, data};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      while (!(aw_ok && w_ok) && t < 50) begin
         @(negedge aclk);
         aw_hit = s_axi_awready && !aw_ok;
         w_hit = s_axi_wready && !w_ok;
         @(posedge aclk);
         t++;
         if (aw_hit) begin
            aw_ok = 1'h1;
            s_axi_awvalid <= 1'h0;
         end
         if (w_hit) begin
            w_ok = 1'h1;
            s_axi_wvalid <= 1'h0;
         end
      end
      if (!(aw_ok && w_ok)) check(32'h0, 32'h1, "write taken");
      s_axi_bready <= 1'h1;
      do begin
         @(negedge aclk);
         aw_hit = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge aclk);
         t++;
      end while (!aw_hit && t < 100);
      s_axi_bready <= 1'h0;
      if (!aw_hit) check(32'h0, 32'h1, "write answer");
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
      logic hit;
      int t;
      t = 0;
      @(posedge aclk);
      s_axi_araddr <= addr;
      s_axi_arvalid <= 1'h1;
      do begin
         @(negedge aclk);
         hit = s_axi_arready;
         @(posedge aclk);
         t++;
      end while (!hit && t < 50);
      s_axi_arvalid <= 1'h0;
      s_axi_rready <= 1'h1;
      do begin
         @(negedge aclk);
         hit = s_axi_rvalid;
         data = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge aclk);
         t++;
      end while (!hit && t < 100);
      s_axi_rready <= 1'h0;
      if (!hit) check(32'h0, 32'h1, "read answer");
   endtask : axi_rd

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      logic [1:0] resp;
      axi_wr(addr, data, resp);
      check({30'h0, resp}, {30'h0, `MFIB_RESP_OKAY}, "write resp");
   endtask : wr

   task automatic rd_check(input logic [7:0] addr, input logic [31:0] exp, input string what);
      logic [31:0] data;
      logic [1:0] resp;
      axi_rd(addr, data, resp);
      check(data, exp, what);
      check({30'h0, resp}, {30'h0, `MFIB_RESP_OKAY}, "read resp");
   endtask : rd_check

   task automatic pulse(input logic [6:0] ev);
      @(posedge aclk);
      events <= ev;
      @(posedge aclk);
      events <= 7'h00;
   endtask : pulse

   task automatic t_reset();
      for (int i = 0; i < 5; i++) rd_check(offs[i], 32'h0, "reset value");
      check({27'h0, req, irq, wake}, 32'h0, "outputs idle");
      $display("test reset done");
   endtask : t_reset

   task automatic t_access();
      logic [7:0] wv [4] = '{8'hFF, 8'h44, 8'hCC, 8'h00};
      logic [31:0] data;
      logic [1:0] resp;
      for (int r = 0; r < 3; r++) begin
         for (int v = 0; v < 4; v++) begin
            wr(offs[r], wv[v]);
            rd_check(offs[r], {24'h0, wv[v] & impl[r]}, "read back");
         end
      end
      // lane 0 strobe low: answered but nothing changes
      s_axi_wstrb <= 4'hE;
      wr(offs[0], 8'hFF);
      s_axi_wstrb <= 4'hF;
      rd_check(offs[0], 32'h0, "strobe off write ignored");
      // unmapped word answers with an error and no data
      axi_wr(8'h14, 8'hFF, resp);
      check({30'h0, resp}, {30'h0, `MFIB_RESP_SLVERR}, "unmapped write");
      axi_rd(8'h14, data, resp);
      check({data[29:0], resp}, {30'h0, `MFIB_RESP_SLVERR}, "unmapped read");
      $display("test access done");
   endtask : t_access

   task automatic t_events();
      int r;
      for (int e = 0; e < 7; e++) begin
         r = reg_of[e];
         pulse(7'h40 >> e);
         @(negedge aclk);
         check({31'h0, wake}, 32'h1, "wake pulse");
         check({31'h0, irq}, 32'h0, "irq masked off");
         @(negedge aclk);
         check({31'h0, wake}, 32'h0, "wake single cycle");
         rd_check(offs[r], {24'h0, flag_of[e]}, "flag set");
         check({29'h0, req}, 32'h0, "no req while disabled");
         // enable sits four places below its flag
         wr(offs[r], flag_of[e] | (flag_of[e] >> 4));
         @(negedge aclk);
         check({29'h0, req}, {29'h0, 3'h1 << r}, "combined req");
         wr(offs[r], 8'h00);
         @(negedge aclk);
         check({29'h0, req}, 32'h0, "req after clear");
      end
      $display("test events done");
   endtask : t_events

   task automatic collide(input logic [7:0] addr, input logic [7:0] data);
      logic [1:0] resp;
      fork
         axi_wr(addr, data, resp);
         begin
            // the write lands one edge after both halves are taken
            repeat (2) @(posedge aclk);
            events <= 7'h40;
            @(posedge aclk);
            events <= 7'h00;
         end
      join
   endtask : collide

   task automatic t_collide();
      pulse(7'h40);
      collide(offs[0], 8'h00);
      rd_check(offs[0], 32'h80, "event beats clear");
      collide(offs[3], 8'h07);
      rd_check(offs[3], 32'h1, "event beats status clear");
      wr(offs[0], 8'h00);
      $display("test collide done");
   endtask : t_collide

   task automatic t_irq();
      wr(offs[3], 8'h07);
      rd_check(offs[3], 32'h0, "status cleared");
      wr(offs[4], 8'h02);
      pulse(7'h08);
      @(negedge aclk);
      check({31'h0, irq}, 32'h1, "irq raised");
      rd_check(offs[3], 32'h2, "status sticky");
      wr(offs[4], 8'h00);
      @(negedge aclk);
      check({31'h0, irq}, 32'h0, "irq masked");
      rd_check(offs[3], 32'h2, "status kept");
      wr(offs[4], 8'h02);
      @(negedge aclk);
      check({31'h0, irq}, 32'h1, "irq unmasked");
      wr(offs[3], 8'h02);
      @(negedge aclk);
      check({31'h0, irq}, 32'h0, "irq after clear");
      pulse(7'h40);
      @(negedge aclk);
      check({31'h0, irq}, 32'h0, "other bit masked");
      rd_check(offs[3], 32'h1, "status misc");
      rd_check(offs[4], 32'h2, "mask kept");
      $display("test irq done");
   endtask : t_irq

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up

   // whole run is a few hundred cycles; far beyond that means a hang
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      $display("watchdog expired at %0t", $time);
      wrap_up();
   end

   initial begin
      n_mismatch = 0;
      comparisons = 0;
      aresetn = 1'h0;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      s_axi_wvalid = 1'h0;
      s_axi_bready = 1'h0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'h0;
      s_axi_rready = 1'h0;
      events = 7'h00;
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_reset();
      t_access();
      t_events();
      t_collide();
      t_irq();
      wrap_up();
   end
endmodule : multifunction_irq_flag_bank_test
`default_nettype wire
